// ---- src/analog_ref_torque_monitor.sv ----
/*
 * Analog terminal function routing, keypad reference save, reference loss
 * detection, bus undervoltage flag and torque detectors.
 * Assumes synchronous inputs, levels in percent, frequencies in 0.01 Hz units.
 */
`timescale 1ns/1ps
module analog_ref_torque_monitor
    import torque_mon_pkg::*;
#(
    parameter int AW = 12,
    parameter int FW = 16,
    parameter int TW = 16
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic          shared_terminal_form_select,
    input  wire logic [7:0]    voltage_terminal_function,
    input  wire logic [7:0]    current_terminal_function,
    input  wire logic [7:0]    alt_voltage_terminal_function,
    output logic [7:0]         voltFnEff,
    output logic [7:0]         curFnEff,
    output logic [7:0]         altFnEff,
    output logic               fnCodeValid,
    input  wire logic          keypad_ref_save_mode,
    input  wire logic [FW-1:0] keypadRef,
    input  wire logic          saveKey,
    input  wire logic          powerOffEvent,
    input  wire logic          powerOnEvent,
    output logic [FW-1:0]      keypadRefRestored,
    input  wire logic [AW-1:0] analogRaw,
    input  wire logic [FW-1:0] analogFreq,
    input  wire logic [9:0]    ref_loss_ratio,
    output logic               refLossFlag,
    output logic [FW-1:0]      runFreq,
    output logic               decelStop,
    output logic               ratioValid,
    input  wire logic [7:0]    outTerminalCode,
    output logic               outTerminal,
    input  wire logic [AW-1:0] busVoltage,
    input  wire logic [AW-1:0] bus_undervoltage_level,
    output logic               bus_undervoltage_flag,
    input  wire logic [TW-1:0] torqueValue,
    input  wire logic [TW-1:0] torque_level_one,
    input  wire logic [TW-1:0] torque_timer_one,
    input  wire logic [TW-1:0] torque_level_two,
    input  wire logic [TW-1:0] torque_timer_two,
    input  wire logic [FW-1:0] outFreq,
    input  wire logic [FW-1:0] base_frequency,
    input  wire logic          running,
    output logic               over_torque_one,
    output logic               over_torque_two,
    output logic               low_torque_flag
);
    initial begin
        if (AW < 8 || FW < 8 || TW < 8) $error("analog_ref_torque_monitor: width too small");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [15:0]   tickCnt;
        logic [7:0]    sampCnt;
        logic [AW-1:0] f1;
        logic [8:0]    winCnt;
        ref_state_t    refSt;
        logic [FW-1:0] savedRef;
        logic [FW-1:0] restored;
        logic [7:0]    voltFn;
        logic [7:0]    curFn;
        logic [7:0]    altFn;
        logic          fnOk;
        logic          uv;
        logic [FW-1:0] run;
        logic          dstop;
        logic          outT;
    } mon_t;

    mon_t st_r;
    mon_t st_nxt;
    logic tick;
    logic lowFreqHold;
    logic lowDet;
    logic [AW+7:0] lossThr;
    logic [AW+7:0] recThr;
    logic [AW+7:0] curScaled;
    logic [FW+9:0] subst;

    function automatic logic fnKnown(input logic [7:0] c);
        fnKnown = (c <= 8'h07) || c == FN_TRQ_LIM_B || c == FN_TRQ_BIAS || c == FN_TRQ_CMD
                  || c == FN_TRQ_CUR_CMD || c == FN_SPD_LIM_FWD || c == FN_SPD_LIM_REV
                  || c == FN_MONITOR;
    endfunction

    assign tick = (st_r.tickCnt == 16'(TICK_CYCLES - 1));     // [R23]

    // Loss and recovery thresholds relative to the sampled level f1
    assign curScaled = (AW+8)'(analogRaw) * (AW+8)'(100);     // [R16]
    assign lossThr   = (AW+8)'(st_r.f1) * (AW+8)'(LOSS_PCT);  // [R8]
    always_comb begin
        if (ref_loss_ratio == RATIO_STOP || ref_loss_ratio == RATIO_OFF) begin
            recThr = (AW+8)'(st_r.f1) * (AW+8)'(RECOV_PCT);   // [R14]
        end else if (ref_loss_ratio >= RATIO_FULL) begin
            recThr = (AW+8)'(st_r.f1) * (AW+8)'(100);         // [R15]
        end else begin
            recThr = (AW+8)'(st_r.f1) * (AW+8)'(ref_loss_ratio); // [R10]
        end
    end
    assign subst = (FW+10)'(analogFreq) * (FW+10)'(ref_loss_ratio) / (FW+10)'(100);

    // Low frequency range freezes low torque evaluation
    assign lowFreqHold = ((FW+8)'(outFreq) * (FW+8)'(100))
                         < ((FW+8)'(base_frequency) * (FW+8)'(LOWF_PCT)); // [R21]

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.tickCnt = tick ? 16'h0000 : st_r.tickCnt + 16'h0001;

        // Terminal function routing
        st_nxt.voltFn = voltage_terminal_function;
        st_nxt.curFn  = (shared_terminal_form_select == FORM_CURRENT)           // [R1] [R5]
                        ? current_terminal_function : FN_NONE;
        st_nxt.altFn  = (shared_terminal_form_select == FORM_VOLTAGE)
                        ? alt_voltage_terminal_function : FN_NONE;
        if (st_nxt.curFn == voltage_terminal_function) st_nxt.curFn = FN_NONE;  // [R4]
        if (st_nxt.altFn == voltage_terminal_function) st_nxt.altFn = FN_NONE;  // [R4]
        st_nxt.fnOk = fnKnown(voltage_terminal_function)                        // [R2] [R3]
                      && fnKnown(current_terminal_function)
                      && fnKnown(alt_voltage_terminal_function);

        // Keypad reference save and restore
        if ((keypad_ref_save_mode == SAVE_AUTO && powerOffEvent)                // [R6]
            || (keypad_ref_save_mode == SAVE_KEY && saveKey)) begin             // [R7]
            st_nxt.savedRef = keypadRef;
        end
        if (powerOnEvent) st_nxt.restored = st_r.savedRef;                      // [R6] [R7]

        // Bus undervoltage flag
        if (busVoltage < bus_undervoltage_level) st_nxt.uv = 1'b1;               // [R17]
        else if (busVoltage > bus_undervoltage_level) st_nxt.uv = 1'b0;

        // Reference loss detection on the periodic tick
        if (tick) begin
            case (st_r.refSt)
                REF_OK: begin
                    if (curScaled < lossThr && st_r.winCnt != 9'h000) begin     // [R8]
                        st_nxt.refSt = REF_LOST;
                    end else if (st_r.sampCnt == 8'(SAMPLE_TK - 1)) begin       // [R11]
                        st_nxt.sampCnt = 8'h00;
                        st_nxt.f1      = analogRaw;
                        st_nxt.winCnt  = 9'(LOSS_WINDOW_TK);
                    end else begin
                        st_nxt.sampCnt = st_r.sampCnt + 8'h01;
                        if (st_r.winCnt != 9'h000) st_nxt.winCnt = st_r.winCnt - 9'h001;
                    end
                end
                REF_LOST: begin
                    if (curScaled > recThr) begin                               // [R10]
                        st_nxt.refSt   = REF_OK;
                        st_nxt.sampCnt = 8'h00;
                        st_nxt.winCnt  = 9'h000;
                    end
                end
                default: st_nxt.refSt = REF_OK;
            endcase
        end

        // Running frequency while lost
        st_nxt.dstop = 1'b0;
        st_nxt.run   = analogFreq;
        if (st_r.refSt == REF_LOST) begin
            if (ref_loss_ratio == RATIO_STOP) begin                             // [R12]
                st_nxt.dstop = 1'b1;
                st_nxt.run   = '0;
            end else if (ref_loss_ratio != RATIO_OFF) begin                     // [R13]
                st_nxt.run = FW'(subst);                                        // [R8]
            end
        end

        // Programmable output terminal
        if (outTerminalCode == OUT_REF_LOSS) st_nxt.outT = st_r.refSt == REF_LOST; // [R9]
        else if (outTerminalCode == OUT_BUS_UV) st_nxt.outT = st_r.uv;              // [R17]
        else st_nxt.outT = 1'b0;
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) st_r <= '0;                                                 // [R23]
        else        st_r <= st_nxt;
    end

    // ****************************************************************
    // Torque detectors
    // ****************************************************************
    // First pair feeds over-torque one, second pair the other two
    torque_detector #(.TW(TW), .UNDER(1'b0)) u_td1 (                            // [R18]
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .tick       (tick),
        .hold       (1'b0),
        .forceOff   (1'b0),
        .torque     (torqueValue),
        .level      (torque_level_one),
        .timerTicks (torque_timer_one),
        .detect     (over_torque_one)
    );
    torque_detector #(.TW(TW), .UNDER(1'b0)) u_td2 (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .tick       (tick),
        .hold       (1'b0),
        .forceOff   (1'b0),
        .torque     (torqueValue),
        .level      (torque_level_two),
        .timerTicks (torque_timer_two),
        .detect     (over_torque_two)
    );
    torque_detector #(.TW(TW), .UNDER(1'b1)) u_lt (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .tick       (tick),
        .hold       (lowFreqHold),                                              // [R21]
        .forceOff   (!running),                                                 // [R22]
        .torque     (torqueValue),
        .level      (torque_level_two),
        .timerTicks (torque_timer_two),
        .detect     (lowDet)
    );
    assign low_torque_flag = lowDet;

    // Outputs from state; ratioValid is decoded directly from ref_loss_ratio
    assign voltFnEff             = st_r.voltFn;
    assign curFnEff              = st_r.curFn;
    assign altFnEff              = st_r.altFn;
    assign fnCodeValid           = st_r.fnOk;
    assign keypadRefRestored     = st_r.restored;
    assign refLossFlag           = (st_r.refSt == REF_LOST);
    assign runFreq               = st_r.run;
    assign decelStop             = st_r.dstop;
    assign ratioValid            = ref_loss_ratio == RATIO_STOP || ref_loss_ratio == RATIO_OFF
                                   || (ref_loss_ratio >= RATIO_MIN && ref_loss_ratio <= RATIO_MAX);
    assign outTerminal           = st_r.outT;
    assign bus_undervoltage_flag = st_r.uv;
endmodule

// ---- shared/torque_mon_pkg.sv ----
/*
 * Constants, codes and states for the analog reference and torque monitor.
 * Assumes a 20 MHz system clock and a synchronous active-low reset.
 */
// Operation
// R1: Form select 0 makes shared terminal current input, 1 makes it voltage input.
// R2: Function codes 8, 9, 10, 11 select torque limiter B, bias, command, current command.
// R3: Codes 17, 18 are forward/reverse speed limits; 20 is analog monitor input.
// R4: Duplicate function codes: only the voltage terminal selector is honoured.
// R5: Only the shared-terminal selector matching the chosen form is enabled.
// R6: Save mode 0 stores keypad reference at power-off, restores at power-on.
// R7: Save mode 1 stores only on save key; unsaved changes are lost.
// R8: Command drop below 10% within 400 ms flags loss and runs at ratio.
// R9: Loss flag reaches an output terminal assigned code 33.
// R10: Loss clears and command is followed once level exceeds recovery level.
// R11: Command level is sampled at regular intervals as wire-break basis.
// R12: Loss ratio accepts 0 (stop), 20 to 120 percent, or 999 (disabled).
// R13: Ratio 999 still flags loss but keeps following the analog command.
// R14: Ratio 0 or 999 restores once command exceeds 0.2 times sampled level.
// R15: Ratio 100 percent or more restores once command reaches sampled level; the code restores only once the command exceeds that level.
// R16: Loss detection uses the unfiltered input, ignoring filter settings.
// R17: Undervoltage flag set below programmed level, cleared above; code 77.
// R18: Pair one drives over-torque one; pair two drives over-torque two and low torque.
// R19: Over-torque sets after level held for timer; clears below level minus 5%; 100 ms.
// R20: Low torque sets below level two for timer; clears above level plus 5%; 100 ms.
// R21: Below 20% base frequency low-torque detection frozen at prior result.
// R22: Low-torque output forced off whenever the inverter is stopped.
// R23: All comparators and timers run on a periodic tick; reset clears all flags. The bus undervoltage comparator updates every clock instead.
package torque_mon_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ          = 20000000;
    localparam int TICK_US         = 1000;
    localparam int TICK_CYCLES     = CLK_HZ / 1000000 * TICK_US;
    localparam int LOSS_WINDOW_MS  = 400;
    localparam int LOSS_WINDOW_TK  = LOSS_WINDOW_MS * 1000 / TICK_US;
    localparam int MIN_ON_MS       = 100;
    localparam int MIN_ON_TK       = MIN_ON_MS * 1000 / TICK_US;
    localparam int SAMPLE_TK       = 50;

    // ****************************************************************
    // Codes and ranges
    // ****************************************************************
    localparam logic [7:0] FN_NONE        = 8'h00;
    localparam logic [7:0] FN_TRQ_LIM_B   = 8'h08;
    localparam logic [7:0] FN_TRQ_BIAS    = 8'h09;
    localparam logic [7:0] FN_TRQ_CMD     = 8'h0A;
    localparam logic [7:0] FN_TRQ_CUR_CMD = 8'h0B;
    localparam logic [7:0] FN_SPD_LIM_FWD = 8'h11;
    localparam logic [7:0] FN_SPD_LIM_REV = 8'h12;
    localparam logic [7:0] FN_MONITOR     = 8'h14;
    localparam logic [7:0] OUT_REF_LOSS   = 8'h21;
    localparam logic [7:0] OUT_BUS_UV     = 8'h4D;
    localparam logic [9:0] RATIO_STOP     = 10'h000;
    localparam logic [9:0] RATIO_MIN      = 10'h014;
    localparam logic [9:0] RATIO_MAX      = 10'h078;
    localparam logic [9:0] RATIO_FULL     = 10'h064;
    localparam logic [9:0] RATIO_OFF      = 10'h3E7;
    localparam int LOSS_PCT    = 10;
    localparam int RECOV_PCT   = 20;
    localparam int HYST_PCT    = 5;
    localparam int LOWF_PCT    = 20;
    localparam logic FORM_CURRENT = 1'b0;
    localparam logic FORM_VOLTAGE = 1'b1;
    localparam logic SAVE_AUTO    = 1'b0;
    localparam logic SAVE_KEY     = 1'b1;

    typedef enum logic [1:0] {
        REF_OK   = 2'b00,
        REF_LOST = 2'b01
    } ref_state_t;

endpackage

// ---- src/torque_detector.sv ----
/*
 * One torque detector: level, on-timer, 5% hysteresis and minimum on-time.
 * Assumes a one-cycle tick pulse and torque in percent of rated torque.
 */
`timescale 1ns/1ps
module torque_detector
    import torque_mon_pkg::*;
#(
    parameter int TW    = 16,
    parameter bit UNDER = 1'b0
) (
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic          tick,
    input  wire logic          hold,
    input  wire logic          forceOff,
    input  wire logic [TW-1:0] torque,
    input  wire logic [TW-1:0] level,
    input  wire logic [TW-1:0] timerTicks,
    output logic               detect
);
    initial begin
        if (TW < 8) $error("torque_detector: TW too small");
    end

    typedef struct packed {
        logic [TW-1:0] cnt;
        logic [7:0]    minOn;
        logic          flag;
    } det_t;

    det_t st_r;
    det_t st_nxt;
    logic [TW:0] lvlHi;
    logic [TW:0] lvlLo;
    logic        beyond;
    logic        back;

    // Hysteresis band around the level
    assign lvlHi  = {1'b0, level} + (TW+1)'(HYST_PCT);
    assign lvlLo  = ({1'b0, level} > (TW+1)'(HYST_PCT)) ? {1'b0, level} - (TW+1)'(HYST_PCT)
                                                        : '0;
    assign beyond = UNDER ? (torque < level) : (torque > level);
    assign back   = UNDER ? ({1'b0, torque} > lvlHi) : ({1'b0, torque} < lvlLo);

    // Set after timer, clear on hysteresis once minimum on-time elapsed
    always_comb begin
        st_nxt = st_r;
        if (forceOff) begin
            st_nxt = '0;                                      // [R22]
        end else if (tick && !hold) begin                     // [R21] [R23]
            if (!st_r.flag) begin
                if (!beyond) begin
                    st_nxt.cnt = '0;
                end else if (st_r.cnt >= timerTicks) begin    // [R19] [R20]
                    st_nxt.flag  = 1'b1;
                    st_nxt.minOn = 8'(MIN_ON_TK);
                end else begin
                    st_nxt.cnt = st_r.cnt + TW'(1);
                end
            end else begin
                if (st_r.minOn != 8'h00) begin
                    st_nxt.minOn = st_r.minOn - 8'h01;
                end else if (back) begin                      // [R19] [R20]
                    st_nxt.flag = 1'b0;
                    st_nxt.cnt  = '0;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) st_r <= '0;                               // [R23]
        else        st_r <= st_nxt;
    end

    assign detect = st_r.flag;
endmodule

// ---- sim/torque_mon_monitor.sv ----
/*
 * Port checker for the analog reference and torque monitor.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module torque_mon_monitor
    import torque_mon_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic          clk_sys,
    input wire logic          rst_n,
    input wire logic          shared_terminal_form_select,
    input wire logic [7:0]    voltage_terminal_function,
    input wire logic [7:0]    current_terminal_function,
    input wire logic [7:0]    voltFnEff,
    input wire logic [7:0]    curFnEff,
    input wire logic [7:0]    altFnEff,
    input wire logic [9:0]    ref_loss_ratio,
    input wire logic          ratioValid,
    input wire logic [7:0]    outTerminalCode,
    input wire logic          outTerminal,
    input wire logic [AW-1:0] busVoltage,
    input wire logic [AW-1:0] bus_undervoltage_level,
    input wire logic          bus_undervoltage_flag,
    input wire logic          refLossFlag,
    input wire logic          over_torque_one,
    input wire logic          over_torque_two,
    input wire logic          low_torque_flag
);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    uv_set_a: assert property (busVoltage < bus_undervoltage_level
        |=> bus_undervoltage_flag)
        else $error("undervoltage flag not set");
    uv_clear_a: assert property (busVoltage > bus_undervoltage_level
        |=> !bus_undervoltage_flag)
        else $error("undervoltage flag not cleared");
    uv_hold_a: assert property (busVoltage == bus_undervoltage_level
        |=> $stable(bus_undervoltage_flag))
        else $error("undervoltage flag moved at equal level");
    term_uv_a: assert property ((outTerminalCode == OUT_BUS_UV && $stable(outTerminalCode)
        && $stable(busVoltage) && $stable(bus_undervoltage_level) && $past(rst_n))
        |=> outTerminal == bus_undervoltage_flag)
        else $error("output terminal does not follow undervoltage");
    term_off_a: assert property ((outTerminalCode != OUT_REF_LOSS && outTerminalCode != OUT_BUS_UV)
        |=> !outTerminal)
        else $error("output terminal active on other code");
    volt_fn_a: assert property (1'b1 |=> voltFnEff == $past(voltage_terminal_function))
        else $error("voltage terminal code not honoured");
    form_cur_a: assert property (shared_terminal_form_select == FORM_CURRENT
        |=> altFnEff == 8'h00)
        else $error("alternate selector enabled in current form");
    form_volt_a: assert property (shared_terminal_form_select == FORM_VOLTAGE
        |=> curFnEff == 8'h00)
        else $error("current selector enabled in voltage form");
    dup_cur_a: assert property (current_terminal_function == voltage_terminal_function
        |=> curFnEff == 8'h00)
        else $error("duplicate code not suppressed");
    ratio_chk_a: assert property (ratioValid == (ref_loss_ratio == RATIO_STOP || ref_loss_ratio ==
        RATIO_OFF || (ref_loss_ratio >= RATIO_MIN && ref_loss_ratio <= RATIO_MAX)))
        else $error("loss ratio range check wrong");
    reset_clear_a: assert property (disable iff (1'b0) !rst_n |=> !refLossFlag && !over_torque_one
        && !over_torque_two && !low_torque_flag && !bus_undervoltage_flag)
        else $error("flag not cleared by reset");

    // Main scenarios reached
    cover property (bus_undervoltage_flag);
    cover property ($rose(over_torque_one));
    cover property ($rose(low_torque_flag));
endmodule

// ---- sim/terminal_sensor_model.sv ----
/*
 * Behavioural bus voltage and torque sensors on the terminals.
 * Assumes setpoints change at the falling edge; outputs follow one falling edge later.
 */
`timescale 1ns/1ps
module terminal_sensor_model (
    input  wire logic        clk_sys,
    input  wire logic [11:0] busSet,
    input  wire logic [15:0] torqueSet,
    output logic      [11:0] busVoltage,
    output logic      [15:0] torqueValue
);
    // Sensor outputs settle away from the sampling edge
    always @(negedge clk_sys) begin
        busVoltage <= busSet;
        torqueValue <= torqueSet;
    end
endmodule

// ---- sim/analog_ref_torque_monitor_tb_top.sv ----
/*
 * Self-checking bench for the analog reference and torque monitor.
 * Assumes a 50 ns clock; inputs change at the falling edge.
 */
`timescale 1ns/1ps
module analog_ref_torque_monitor_tb_top;
    import torque_mon_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, shared_terminal_form_select = 1'b0;
    logic [7:0] voltage_terminal_function = 8'h00, current_terminal_function = 8'h00;
    logic [7:0] alt_voltage_terminal_function = 8'h00, outTerminalCode = 8'h00;
    logic keypad_ref_save_mode = 1'b0, saveKey = 1'b0, powerOffEvent = 1'b0, powerOnEvent = 1'b0;
    logic [15:0] keypadRef = 16'h0000, analogFreq = 16'h1388, outFreq = 16'h1388;
    logic [15:0] base_frequency = 16'h1388, torqueSet = 16'h0064;
    logic [15:0] torque_level_one = 16'h0032, torque_timer_one = 16'h0001;
    logic [15:0] torque_level_two = 16'h00C8, torque_timer_two = 16'h0001;
    logic [11:0] analogRaw = 12'h800, bus_undervoltage_level = 12'h000, busSet = 12'h3FF;
    logic [9:0] ref_loss_ratio = 10'h064;
    logic running = 1'b1;
    logic [7:0] voltFnEff, curFnEff, altFnEff;
    logic [15:0] keypadRefRestored, runFreq, torqueValue;
    logic [11:0] busVoltage;
    logic fnCodeValid, refLossFlag, decelStop, ratioValid, outTerminal, bus_undervoltage_flag;
    logic over_torque_one, over_torque_two, low_torque_flag;
    int err_total = 0;
    int samples_checked = 0;

    // Clock
    always #25 clk_sys = ~clk_sys;

    terminal_sensor_model u_sens (.clk_sys, .busSet, .torqueSet, .busVoltage, .torqueValue);

    analog_ref_torque_monitor dut (.clk_sys, .rst_n, .shared_terminal_form_select,
        .voltage_terminal_function, .current_terminal_function, .alt_voltage_terminal_function,
        .voltFnEff, .curFnEff, .altFnEff, .fnCodeValid, .keypad_ref_save_mode, .keypadRef,
        .saveKey, .powerOffEvent, .powerOnEvent, .keypadRefRestored, .analogRaw, .analogFreq,
        .ref_loss_ratio, .refLossFlag, .runFreq, .decelStop, .ratioValid, .outTerminalCode,
        .outTerminal, .busVoltage, .bus_undervoltage_level, .bus_undervoltage_flag,
        .torqueValue, .torque_level_one, .torque_timer_one, .torque_level_two,
        .torque_timer_two, .outFreq, .base_frequency, .running, .over_torque_one,
        .over_torque_two, .low_torque_flag);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic step();
        @(negedge clk_sys);
    endtask

    task automatic settle();
        repeat (3) step();
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        step();
        s = 1'b0;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_route();
        logic [7:0] codes [7] = '{FN_TRQ_LIM_B, FN_TRQ_BIAS, FN_TRQ_CMD, FN_TRQ_CUR_CMD,
                                  FN_SPD_LIM_FWD, FN_SPD_LIM_REV, FN_MONITOR};
        foreach (codes[i]) begin
            voltage_terminal_function = codes[i];
            step();
            chk(voltFnEff, codes[i]);
            chk(fnCodeValid, 1'b1);
        end
        voltage_terminal_function = 8'h0C;
        step();
        chk(fnCodeValid, 1'b0);
        voltage_terminal_function = FN_TRQ_BIAS;
        current_terminal_function = FN_TRQ_BIAS;
        step();
        chk(curFnEff, 8'h00);
        voltage_terminal_function = FN_TRQ_LIM_B;
        current_terminal_function = FN_TRQ_CMD;
        alt_voltage_terminal_function = FN_TRQ_CUR_CMD;
        step();
        chk(curFnEff, FN_TRQ_CMD);
        chk(altFnEff, 8'h00);
        shared_terminal_form_select = FORM_VOLTAGE;
        step();
        chk(curFnEff, 8'h00);
        chk(altFnEff, FN_TRQ_CUR_CMD);
    endtask

    task automatic t_save();
        keypad_ref_save_mode = SAVE_AUTO;
        keypadRef = 16'h04D2;
        pulse(powerOffEvent);
        keypadRef = 16'h15B3;
        pulse(saveKey);
        pulse(powerOnEvent);
        chk(keypadRefRestored, 16'h04D2);
        keypad_ref_save_mode = SAVE_KEY;
        keypadRef = 16'h08AE;
        pulse(saveKey);
        keypadRef = 16'h0D05;
        pulse(powerOffEvent);
        pulse(powerOnEvent);
        chk(keypadRefRestored, 16'h08AE);
    endtask

    task automatic t_uv();
        bus_undervoltage_level = 12'h0C8;
        outTerminalCode = OUT_BUS_UV;
        busSet <= 12'h064;
        settle();
        chk(bus_undervoltage_flag, 1'b1);
        chk(outTerminal, 1'b1);
        busSet <= 12'h0C8;
        settle();
        chk(bus_undervoltage_flag, 1'b1);
        busSet <= 12'h12C;
        settle();
        chk(bus_undervoltage_flag, 1'b0);
        chk(outTerminal, 1'b0);
        outTerminalCode = OUT_REF_LOSS;
        busSet <= 12'h064;
        settle();
        chk(outTerminal, 1'b0);
    endtask

    task automatic t_ratio();
        logic [9:0] vals [7] = '{10'h000, 10'h013, 10'h014, 10'h078, 10'h079, 10'h3E7, 10'h1F4};
        logic exps [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        foreach (vals[i]) begin
            ref_loss_ratio = vals[i];
            step();
            chk(ratioValid, exps[i]);
        end
        analogFreq = 16'h0BB8;
        step();
        chk(runFreq, 16'h0BB8);
        chk(decelStop, 1'b0);
        chk(refLossFlag, 1'b0);
        ref_loss_ratio = 10'h064;
    endtask

    task automatic t_torque();
        int n = 0;
        while (!(over_torque_one === 1'b1 && low_torque_flag === 1'b1) && n < 80000) begin
            step();
            n++;
        end
        chk(over_torque_one, 1'b1);
        chk(low_torque_flag, 1'b1);
        chk(over_torque_two, 1'b0);
        running = 1'b0;
        n = 0;
        while (low_torque_flag !== 1'b0 && n < 20100) begin
            step();
            n++;
        end
        chk(low_torque_flag, 1'b0);
        chk(over_torque_one, 1'b1);
    endtask

    // Main sequence
    initial begin
        repeat (16) step();
        rst_n = 1'b1;
        step();
        t_route();
        t_save();
        t_uv();
        t_ratio();
        t_torque();
        end_sim();
    end

    // Watchdog
    initial begin
        repeat (50000) @(posedge clk_sys);
        err_total++;
        end_sim();
    end
endmodule

bind analog_ref_torque_monitor torque_mon_monitor #(.AW(AW)) u_mon (.clk_sys, .rst_n,
    .shared_terminal_form_select, .voltage_terminal_function, .current_terminal_function,
    .voltFnEff, .curFnEff, .altFnEff, .ref_loss_ratio, .ratioValid, .outTerminalCode,
    .outTerminal, .busVoltage, .bus_undervoltage_level, .bus_undervoltage_flag,
    .refLossFlag, .over_torque_one, .over_torque_two, .low_torque_flag);
